// ---- core/ep_cfg_pkg.sv ----
// Constants for the per-endpoint packet-size and type configuration bank
package ep_cfg_pkg;
   localparam int unsigned ADDR_W             = 8;
   localparam int unsigned DATA_W             = 16;
   localparam logic [7:0]  PKT_SIZE_OFS       = 8'h04;
   localparam logic [7:0]  EP_TYPE_OFS        = 8'h08;
   localparam logic [7:0]  BYTE_COUNT_OFS     = 8'h1c;
   localparam logic [7:0]  EP_INDEX_OFS       = 8'h20;
   localparam int unsigned NUM_EP             = 16;
   localparam int unsigned NUM_CTRL_EP        = 2;
   localparam int unsigned INDEX_W            = 4;
   localparam int unsigned FIFO_SIZE_LSB      = 0;
   localparam int unsigned FIFO_SIZE_W        = 11;
   localparam int unsigned TRANS_LSB          = 11;
   localparam int unsigned TRANS_W            = 2;
   localparam int unsigned TYPE_LSB           = 0;
   localparam int unsigned TYPE_W             = 2;
   localparam int unsigned DBL_BUF_BIT        = 2;
   localparam int unsigned ENABLE_BIT         = 3;
   localparam int unsigned NO_ZLP_BIT         = 4;
   localparam int unsigned TYPE_REG_W         = 5;
   localparam logic [1:0]  TYPE_NONE          = 2'h0;
   localparam logic [1:0]  TYPE_ISO           = 2'h1;
   localparam logic [1:0]  TYPE_BULK          = 2'h2;
   localparam logic [1:0]  TYPE_INTR          = 2'h3;
   localparam logic [1:0]  TRANS_ONE          = 2'h0;
   localparam logic [1:0]  TRANS_TWO          = 2'h1;
   localparam logic [1:0]  TRANS_THREE        = 2'h2;
   localparam logic [1:0]  TRANS_RSVD         = 2'h3;
   localparam logic [15:0] PKT_SIZE_RESET     = 16'h0000;
   localparam logic [4:0]  TYPE_RESET         = 5'h00;
   localparam logic [15:0] BYTE_COUNT_RESET   = 16'h0000;
   localparam int unsigned FIFO_TOTAL_BYTES   = 8192;
endpackage

// ---- core/ep_fifo_cfg_regs.sv ----
// Per-endpoint packet-size, byte-count and type registers reached through an endpoint index
`timescale 1ns/1ps
`default_nettype none
module ep_fifo_cfg_regs #(
   parameter int unsigned NUM_EP      = ep_cfg_pkg::NUM_EP,
   parameter int unsigned NUM_CTRL_EP = ep_cfg_pkg::NUM_CTRL_EP
) (
   input  wire logic                            clk_sys_in,
   input  wire logic                            nrst_in,
   input  wire logic                            clk_en_in,
   input  wire logic                            bus_reset_in,
   input  wire logic                            high_speed_in,
   input  wire logic [ep_cfg_pkg::ADDR_W-1:0]   addr_in,
   input  wire logic                            wr_in,
   input  wire logic                            rd_in,
   input  wire logic [ep_cfg_pkg::DATA_W-1:0]   wdata_in,
   output logic      [ep_cfg_pkg::DATA_W-1:0]   rdata_out,
   output logic      [ep_cfg_pkg::INDEX_W-1:0]  ep_index_out,
   output logic      [ep_cfg_pkg::FIFO_SIZE_W-1:0] fifo_size_bytes_out,
   output logic      [1:0]                      packets_per_uframe_out,
   output logic      [ep_cfg_pkg::TYPE_W-1:0]   ep_type_out,
   output logic                                 ep_enable_out,
   output logic                                 double_buffer_out,
   output logic                                 send_zero_length_out,
   output logic      [ep_cfg_pkg::DATA_W-1:0]   packet_byte_count_out
);
   localparam int unsigned IW = ep_cfg_pkg::INDEX_W;
   localparam int unsigned FW = ep_cfg_pkg::FIFO_SIZE_W;
   localparam int unsigned TW = ep_cfg_pkg::TYPE_REG_W;

   // Refused at elaboration: the index must reach every slot and one slot must be programmable
   if (NUM_EP > (1 << IW) || NUM_CTRL_EP >= NUM_EP)
   begin : g_bad_params
      $error("ep_fifo_cfg_regs: endpoint counts do not fit the index");
   end

   logic [IW-1:0]                  idx_q;
   logic [FW-1:0]                  fifo_size_bytes_q [NUM_EP];
   logic [1:0]                     transactions_per_microframe_q [NUM_EP];
   logic [TW-1:0]                  type_cfg_q [NUM_EP];
   logic [ep_cfg_pkg::DATA_W-1:0]  packet_byte_count_q [NUM_EP];
   logic                           wr_pkt, wr_type, wr_cnt, idx_prog;
   logic [TW-1:0]                  cur_type;
   logic [1:0]                     cur_kind;

   assign idx_prog = (32'(idx_q) >= NUM_CTRL_EP) && (32'(idx_q) < NUM_EP);
   assign wr_pkt   = clk_en_in && wr_in && addr_in == ep_cfg_pkg::PKT_SIZE_OFS && idx_prog;
   assign wr_type  = clk_en_in && wr_in && addr_in == ep_cfg_pkg::EP_TYPE_OFS && idx_prog;
   assign wr_cnt   = clk_en_in && wr_in && addr_in == ep_cfg_pkg::BYTE_COUNT_OFS && (32'(idx_q) < NUM_EP);
   assign cur_type = (32'(idx_q) < NUM_EP) ? type_cfg_q[idx_q] : ep_cfg_pkg::TYPE_RESET;
   assign cur_kind = cur_type[ep_cfg_pkg::TYPE_LSB +: ep_cfg_pkg::TYPE_W];

   // Index register; firmware is trusted to set it before any indexed access
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
         idx_q <= '0;
      else if (clk_en_in && wr_in && addr_in == ep_cfg_pkg::EP_INDEX_OFS)
         idx_q <= wdata_in[IW-1:0];
   end

   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++)
      begin : g_ep
         // Control endpoints have fixed sizing, so their packet-size and type slots stay zero
         always_ff @(posedge clk_sys_in or negedge nrst_in)
         begin
            if (!nrst_in)
            begin
               fifo_size_bytes_q[g]             <= ep_cfg_pkg::PKT_SIZE_RESET[FW-1:0];
               transactions_per_microframe_q[g] <= ep_cfg_pkg::TRANS_ONE;
            end
            else if (clk_en_in && bus_reset_in)
            begin
               fifo_size_bytes_q[g]             <= ep_cfg_pkg::PKT_SIZE_RESET[FW-1:0];
               transactions_per_microframe_q[g] <= ep_cfg_pkg::TRANS_ONE;
            end
            else if (wr_pkt && 32'(idx_q) == g)
            begin
               fifo_size_bytes_q[g] <= wdata_in[ep_cfg_pkg::FIFO_SIZE_LSB +: FW];
               transactions_per_microframe_q[g] <= wdata_in[ep_cfg_pkg::TRANS_LSB +: ep_cfg_pkg::TRANS_W];
            end
         end

         always_ff @(posedge clk_sys_in or negedge nrst_in)
         begin
            if (!nrst_in)
               type_cfg_q[g] <= ep_cfg_pkg::TYPE_RESET;
            else if (clk_en_in && bus_reset_in)
               type_cfg_q[g] <= ep_cfg_pkg::TYPE_RESET;
            else if (wr_type && 32'(idx_q) == g)
               type_cfg_q[g] <= wdata_in[TW-1:0];
         end

         // A packet-size write outranks a direct byte-count write to the same slot
         always_ff @(posedge clk_sys_in or negedge nrst_in)
         begin
            if (!nrst_in)
               packet_byte_count_q[g] <= ep_cfg_pkg::BYTE_COUNT_RESET;
            else if (clk_en_in && bus_reset_in)
               packet_byte_count_q[g] <= ep_cfg_pkg::BYTE_COUNT_RESET;
            else if (wr_pkt && 32'(idx_q) == g)
               packet_byte_count_q[g] <= 16'(wdata_in[ep_cfg_pkg::FIFO_SIZE_LSB +: FW]);
            else if (wr_cnt && 32'(idx_q) == g)
               packet_byte_count_q[g] <= wdata_in;
         end
      end
   endgenerate

   // Read data is registered: it appears one enabled edge after the read strobe
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
         rdata_out <= '0;
      else if (clk_en_in && rd_in)
      begin
         rdata_out <= '0;
         if (addr_in == ep_cfg_pkg::EP_INDEX_OFS)
            rdata_out <= 16'(idx_q);
         else if (addr_in == ep_cfg_pkg::PKT_SIZE_OFS && idx_prog)
            rdata_out <= {3'h0, transactions_per_microframe_q[idx_q], fifo_size_bytes_q[idx_q]};
         else if (addr_in == ep_cfg_pkg::EP_TYPE_OFS && idx_prog)
            rdata_out <= 16'(type_cfg_q[idx_q]);
         else if (addr_in == ep_cfg_pkg::BYTE_COUNT_OFS && 32'(idx_q) < NUM_EP)
            rdata_out <= packet_byte_count_q[idx_q];
      end
   end

   // Indexed endpoint view for the transfer engine, registered so every output is a flop
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ep_index_out           <= '0;
         fifo_size_bytes_out    <= '0;
         packets_per_uframe_out <= '0;
         ep_type_out            <= ep_cfg_pkg::TYPE_NONE;
         ep_enable_out          <= 1'b0;
         double_buffer_out      <= 1'b0;
         send_zero_length_out   <= 1'b0;
         packet_byte_count_out  <= '0;
      end
      else if (clk_en_in)
      begin
         ep_index_out          <= idx_q;
         fifo_size_bytes_out   <= idx_prog ? fifo_size_bytes_q[idx_q] : '0;
         ep_type_out           <= cur_kind;
         ep_enable_out         <= cur_type[ep_cfg_pkg::ENABLE_BIT];
         double_buffer_out     <= cur_type[ep_cfg_pkg::DBL_BUF_BIT];
         send_zero_length_out  <= !cur_type[ep_cfg_pkg::NO_ZLP_BIT];
         packet_byte_count_out <= (32'(idx_q) < NUM_EP) ? packet_byte_count_q[idx_q] : '0;
         // Encoded as extra packets: 0 means one. Reserved 11 falls back to one packet.
         if (idx_prog && high_speed_in && (cur_kind == ep_cfg_pkg::TYPE_ISO || cur_kind == ep_cfg_pkg::TYPE_INTR)
             && transactions_per_microframe_q[idx_q] != ep_cfg_pkg::TRANS_RSVD)
            packets_per_uframe_out <= transactions_per_microframe_q[idx_q];
         else
            packets_per_uframe_out <= ep_cfg_pkg::TRANS_ONE;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   sequence pkt_write_s;
      wr_pkt && !bus_reset_in;
   endsequence

   sequence quiet_s;
      clk_en_in && nrst_in && !wr_in && !bus_reset_in;
   endsequence

   count_reload_a: assert property (pkt_write_s |=> packet_byte_count_q[$past(idx_q)] == 16'($past(wdata_in[10:0])))
      else $error("byte count not reloaded from FIFO size");
   size_store_a: assert property (pkt_write_s |=> fifo_size_bytes_q[$past(idx_q)] == $past(wdata_in[10:0]))
      else $error("FIFO size not stored");
   ctrl_untouched_a: assert property (clk_en_in && rd_in && addr_in == ep_cfg_pkg::PKT_SIZE_OFS && !idx_prog |=> rdata_out == 16'h0000)
      else $error("control slot sizing readable");
   bus_reset_clear_a: assert property (clk_en_in && bus_reset_in |=> packet_byte_count_q[$past(idx_q)] == 16'h0000
                                       && fifo_size_bytes_q[$past(idx_q)] == 11'h000)
      else $error("bus reset did not clear endpoint state");
   reserved_zero_a: assert property (clk_en_in && rd_in && addr_in == ep_cfg_pkg::PKT_SIZE_OFS |=> rdata_out[15:13] == 3'h0)
      else $error("reserved bits read nonzero");
   trans_gate_a: assert property (clk_en_in && !high_speed_in |=> packets_per_uframe_out == 2'h0)
      else $error("transactions applied at full speed");
   trans_rsvd_a: assert property (packets_per_uframe_out != 2'h3)
      else $error("reserved transaction code passed through");
   zlp_follow_a: assert property (quiet_s ##1 quiet_s |-> send_zero_length_out == !type_cfg_q[idx_q][4])
      else $error("empty-packet control does not follow type register");
   type_store_a: assert property (wr_type && !bus_reset_in ##1 quiet_s |=> ep_type_out == $past(wdata_in[1:0], 2))
      else $error("endpoint type not applied");
   enable_view_a: assert property (quiet_s ##1 quiet_s |-> ep_enable_out == type_cfg_q[idx_q][3]
                                    && double_buffer_out == type_cfg_q[idx_q][2])
      else $error("enable or double buffer view wrong");

   // Direct count writes, bus reset of the type slot and the registered views
   cnt_write_a: assert property (wr_cnt && !bus_reset_in |=> packet_byte_count_q[$past(idx_q)] == $past(wdata_in))
      else $error("byte count write not stored");
   type_clear_a: assert property (clk_en_in && bus_reset_in |=> type_cfg_q[$past(idx_q)] == ep_cfg_pkg::TYPE_RESET)
      else $error("bus reset did not clear endpoint type");
   ctrl_view_a: assert property (quiet_s ##1 (clk_en_in && !wr_in && !bus_reset_in && nrst_in && !idx_prog)
                                 |-> fifo_size_bytes_out == 11'h000)
      else $error("control index shows a FIFO size");
   index_view_a: assert property (clk_en_in |=> ep_index_out == $past(idx_q))
      else $error("index view does not follow index register");
   byte_view_a: assert property (quiet_s ##1 quiet_s |-> packet_byte_count_out == packet_byte_count_q[idx_q])
      else $error("byte count view wrong");
   rdata_hold_a: assert property (!(clk_en_in && rd_in) |=> $stable(rdata_out))
      else $error("read data changed without a read");
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the endpoint packet-size and type register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module testbench;
   logic        clk_sys_in    = 1'b0;
   logic        nrst_in       = 1'b0;
   logic        clk_en_in     = 1'b1;
   logic        bus_reset_in  = 1'b0;
   logic        high_speed_in = 1'b0;
   logic [7:0]  addr_in       = 8'h00;
   logic        wr_in         = 1'b0;
   logic        rd_in         = 1'b0;
   logic [15:0] wdata_in      = 16'h0000;
   logic [15:0] rdata_out;
   logic [15:0] packet_byte_count_out;
   logic [3:0]  ep_index_out;
   logic [10:0] fifo_size_bytes_out;
   logic [1:0]  packets_per_uframe_out;
   logic [1:0]  ep_type_out;
   logic        ep_enable_out;
   logic        double_buffer_out;
   logic        send_zero_length_out;
   logic [15:0] exp_q [16];
   logic [2:0]  flags;
   int          n_errors = 0;
   int          checked  = 0;
   int          seed;
   always #5 clk_sys_in = ~clk_sys_in;
   ep_fifo_cfg_regs u_ep_fifo_cfg_regs (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in), .bus_reset_in(bus_reset_in),
      .high_speed_in(high_speed_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
      .rdata_out(rdata_out), .ep_index_out(ep_index_out), .fifo_size_bytes_out(fifo_size_bytes_out),
      .packets_per_uframe_out(packets_per_uframe_out), .ep_type_out(ep_type_out), .ep_enable_out(ep_enable_out),
      .double_buffer_out(double_buffer_out), .send_zero_length_out(send_zero_length_out),
      .packet_byte_count_out(packet_byte_count_out));
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      @(posedge clk_sys_in);
      #1 `CHK("rdata", e, rdata_out)
   endtask
   // Views lag the registers by an enabled cycle, so let them settle
   task automatic settle;
      repeat (3) @(posedge clk_sys_in);
      #1;
   endtask
   function automatic logic [1:0] eff_trans(input logic [1:0] tr, input logic [1:0] t, input logic hs);
      if (hs && (t == ep_cfg_pkg::TYPE_ISO || t == ep_cfg_pkg::TYPE_INTR) && tr != ep_cfg_pkg::TRANS_RSVD)
         return tr;
      return 2'h0;
   endfunction
   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #200us;
      n_errors++;
      wrap_up();
   end
   initial
   begin
      seed = $urandom(58757);
      repeat (16) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      wr(ep_cfg_pkg::EP_INDEX_OFS, 16'h0005);
      rd(ep_cfg_pkg::PKT_SIZE_OFS, 16'h0000);
      rd(ep_cfg_pkg::BYTE_COUNT_OFS, 16'h0000);
      $display("test reset_values done");
      // Fill every programmable slot (2 to 15) first so a shared register would show up on readback
      for (int i = 2; i < 16; i++)
      begin
         exp_q[i] = (i == 2) ? 16'h17ff : {3'h0, 2'(i % 3), 11'($urandom % 400)};
         wr(ep_cfg_pkg::EP_INDEX_OFS, 16'(i));
         wr(ep_cfg_pkg::PKT_SIZE_OFS, exp_q[i] | 16'he000);
      end
      for (int i = 2; i < 16; i++)
      begin
         wr(ep_cfg_pkg::EP_INDEX_OFS, 16'(i));
         rd(ep_cfg_pkg::PKT_SIZE_OFS, exp_q[i]);
         rd(ep_cfg_pkg::BYTE_COUNT_OFS, {5'h00, exp_q[i][10:0]});
         settle();
         `CHK("fifo_size", exp_q[i][10:0], fifo_size_bytes_out)
         `CHK("byte_count", {5'h00, exp_q[i][10:0]}, packet_byte_count_out)
         `CHK("index", 4'(i), ep_index_out)
      end
      $display("test packet_size done");
      wr(ep_cfg_pkg::EP_INDEX_OFS, 16'h0004);
      for (int t = 0; t < 4; t++)
         for (int hs = 0; hs < 2; hs++)
            for (int tr = 0; tr < 4; tr++)
            begin
               flags = 3'($urandom);
               @(posedge clk_sys_in);
               high_speed_in <= 1'(hs);
               wr(ep_cfg_pkg::EP_TYPE_OFS, {11'h000, flags, 2'(t)});
               wr(ep_cfg_pkg::PKT_SIZE_OFS, {3'h0, 2'(tr), 11'h040});
               settle();
               `CHK("type", 2'(t), ep_type_out)
               `CHK("enable", flags[1], ep_enable_out)
               `CHK("double_buf", flags[0], double_buffer_out)
               `CHK("send_zlp", ~flags[2], send_zero_length_out)
               `CHK("trans", eff_trans(2'(tr), 2'(t), 1'(hs)), packets_per_uframe_out)
               `CHK("byte_count", 16'h0040, packet_byte_count_out)
            end
      rd(ep_cfg_pkg::EP_TYPE_OFS, {11'h000, flags, 2'h3});
      $display("test type_and_trans done");
      wr(ep_cfg_pkg::EP_INDEX_OFS, 16'h0001);
      wr(ep_cfg_pkg::PKT_SIZE_OFS, 16'h0123);
      rd(ep_cfg_pkg::PKT_SIZE_OFS, 16'h0000);
      settle();
      `CHK("fifo_size", 11'h000, fifo_size_bytes_out)
      `CHK("index", 4'h1, ep_index_out)
      $display("test control_index done");
      wr(ep_cfg_pkg::EP_INDEX_OFS, 16'h0004);
      wr(ep_cfg_pkg::BYTE_COUNT_OFS, 16'h0021);
      rd(ep_cfg_pkg::BYTE_COUNT_OFS, 16'h0021);
      @(posedge clk_sys_in);
      bus_reset_in <= 1'b1;
      @(posedge clk_sys_in);
      bus_reset_in <= 1'b0;
      rd(ep_cfg_pkg::PKT_SIZE_OFS, 16'h0000);
      rd(ep_cfg_pkg::BYTE_COUNT_OFS, 16'h0000);
      wr(ep_cfg_pkg::EP_INDEX_OFS, 16'h0009);
      rd(ep_cfg_pkg::PKT_SIZE_OFS, 16'h0000);
      @(posedge clk_sys_in);
      clk_en_in <= 1'b0;
      wr(ep_cfg_pkg::PKT_SIZE_OFS, 16'h0055);
      clk_en_in <= 1'b1;
      rd(ep_cfg_pkg::PKT_SIZE_OFS, 16'h0000);
      $display("test bus_reset done");
      wrap_up();
   end
endmodule
`undef CHK
`default_nettype wire
